// file: design/cpmr_pkg.sv
// shared constants, types and helpers of the cpu programming model registers
package cpmr_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W   = 8;
  localparam int PC_W     = 16;
  localparam int SP_W     = 6;
  localparam int MAP_BITS = 13;

  // ----------------------------------------------------------------
  // reset values and fixed patterns
  // ----------------------------------------------------------------
  localparam logic [9:0]      SP_PAGE  = 10'h003;
  localparam logic [SP_W-1:0] SP_TOP   = 6'h3F;
  localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
  localparam logic [2:0]      CCR_ONES = 3'h7;

  // ----------------------------------------------------------------
  // condition flags byte layout
  // ----------------------------------------------------------------
  localparam int CCR_C = 0;
  localparam int CCR_Z = 1;
  localparam int CCR_N = 2;
  localparam int CCR_I = 3;
  localparam int CCR_H = 4;

  typedef enum logic [2:0] {
    IX_NONE  = 3'h1,
    IX_SHORT = 3'h2,
    IX_LONG  = 3'h4
  } cpmr_ix_mode_type;

  // full stack address from the stored pointer bits
  function automatic logic [PC_W-1:0] cpmr_sp_addr(input logic [SP_W-1:0] sp);
    return {SP_PAGE, sp};
  endfunction

endpackage

// file: design/cpmr_core_if.sv
// carrier between the register top and its stack and index helpers
`timescale 1ns/10ps
`default_nettype none
interface cpmr_core_if;
  import cpmr_pkg::*;
  logic                   sp_push;
  logic                   sp_pull;
  logic                   sp_reset;
  logic                   sp_load;
  logic [SP_W-1:0]        sp_data;
  logic [SP_W-1:0]        sp_val;
  logic                   ix_req;
  cpmr_ix_mode_type       ix_mode;
  logic [15:0]            ix_offset;
  logic [DATA_W-1:0]      ix_value;
  logic [15:0]            ea;
  logic                   ea_valid;

  modport top   (output sp_push, sp_pull, sp_reset, sp_load, sp_data,
                 output ix_req, ix_mode, ix_offset, ix_value,
                 input sp_val, ea, ea_valid);
  modport stack (input sp_push, sp_pull, sp_reset, sp_load, sp_data, output sp_val);
  modport index (input ix_req, ix_mode, ix_offset, ix_value, output ea, ea_valid);
endinterface
`default_nettype wire

// file: design/cpmr_stack_ptr.sv
// six-bit stack pointer with wrap inside the stack page
`timescale 1ns/10ps
`default_nettype none
module cpmr_stack_ptr
  import cpmr_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  // link to the top
  cpmr_core_if.stack core
);
  typedef struct packed {
    logic [SP_W-1:0] sp;
  } cpmr_stack_state_type;

  cpmr_stack_state_type state_reg;
  cpmr_stack_state_type state_next;

  always_comb
  begin
    state_next = state_reg;
    if (core.sp_reset)
      state_next.sp = SP_TOP;
    else if (core.sp_load)
      state_next.sp = core.sp_data;
    else if (core.sp_push && !core.sp_pull)
      state_next.sp = state_reg.sp - 6'h01;
    else if (core.sp_pull && !core.sp_push)
      state_next.sp = state_reg.sp + 6'h01;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_reg <= '{sp: SP_TOP};
    else
      state_reg <= state_next;
  end

  // always the next free byte; overflow wraps silently
  assign core.sp_val = state_reg.sp;
endmodule // cpmr_stack_ptr
`default_nettype wire

// file: design/cpmr_index_addr.sv
// indexed operand address former, registered
`timescale 1ns/10ps
`default_nettype none
module cpmr_index_addr
  import cpmr_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  // link to the top
  cpmr_core_if.index core
);
  typedef struct packed {
    logic [15:0] ea;
    logic        valid;
  } cpmr_index_state_type;

  cpmr_index_state_type state_reg;
  cpmr_index_state_type state_next;

  always_comb
  begin
    state_next       = state_reg;
    state_next.valid = core.ix_req;
    if (core.ix_req)
    begin
      case (core.ix_mode)
        IX_NONE:  state_next.ea = {8'h00, core.ix_value};
        IX_SHORT: state_next.ea = {8'h00, core.ix_value} + {8'h00, core.ix_offset[7:0]};
        IX_LONG:  state_next.ea = {8'h00, core.ix_value} + core.ix_offset;
        default:  state_next.ea = state_reg.ea;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      state_reg <= '{ea: 16'h0000, valid: 1'b0};
    else
      state_reg <= state_next;
  end

  assign core.ea       = state_reg.ea;
  assign core.ea_valid = state_reg.valid;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  property p_ix_none;
    core.ix_req && core.ix_mode == IX_NONE |=> core.ea == {8'h00, $past(core.ix_value)};
  endproperty
  a_ix_none: assert property (p_ix_none) else $error("no-offset index address wrong");

  property p_ix_short;
    core.ix_req && core.ix_mode == IX_SHORT |=>
      core.ea == {8'h00, $past(core.ix_value)} + {8'h00, $past(core.ix_offset[7:0])};
  endproperty
  a_ix_short: assert property (p_ix_short) else $error("short-offset address wrong");

  property p_ix_long;
    core.ix_req && core.ix_mode == IX_LONG |=>
      core.ea == {8'h00, $past(core.ix_value)} + $past(core.ix_offset);
  endproperty
  a_ix_long: assert property (p_ix_long) else $error("long-offset address wrong");

  property p_cov_long;
    core.ix_req && core.ix_mode == IX_LONG ##1 core.ea_valid;
  endproperty
  c_cov_long: cover property (p_cov_long);
endmodule // cpmr_index_addr
`default_nettype wire

// file: design/cpmr_regs.sv
// cpu programming model: accumulator, index, stack pointer, program counter, flags
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - stack pointer holds six bits; push below bottom wraps to top of page
// - accumulator is eight bits and keeps its contents through device reset
// - no-offset indexed address is index value with high byte zero
// - short-offset indexed address is index plus eight-bit immediate
// - long-offset indexed address is index plus sixteen-bit immediate
// - index register is also scratch storage and survives device reset
// - reset and stack-reset instruction put pointer at top stack location
// - stack pointer always names the next free stack byte
// - a lone push decrements the pointer, a lone pull increments it; push with pull holds it
// - stack address is fixed ten-bit page pattern above six pointer bits
// - calls take two bytes, interrupts five; overflow wraps silently
// - program counter is sixteen bits; lines above the 8K map ignored
// - program counter steps by one on every fetched byte
// - jumps, branches and interrupts load a new program counter value
// - flags byte holds four result flags and the interrupt mask
// - three unused upper bits of the flags byte read as one
// - device reset changes only the interrupt mask among the flags
// - reset sets the mask; only mask-clear or wait instructions or a flags byte load clear it
// - interrupt entry sets the mask after stacking, before vector fetch
module cpmr_regs
  import cpmr_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              rst_n_in,
  // accumulator
  input  wire logic              acc_load_in,
  input  wire logic [DATA_W-1:0] acc_data_in,
  output logic      [DATA_W-1:0] acc_out,
  // index register and address former
  input  wire logic              idx_load_in,
  input  wire logic [DATA_W-1:0] idx_data_in,
  output logic      [DATA_W-1:0] idx_out,
  input  wire logic              ix_req_in,
  input  wire logic [2:0]        ix_mode_in,
  input  wire logic [15:0]       ix_offset_in,
  output logic      [15:0]       ea_out,
  output logic                   ea_valid_out,
  // stack pointer
  input  wire logic              sp_push_in,
  input  wire logic              sp_pull_in,
  input  wire logic              stack_pointer_reset_instruction_in,
  input  wire logic              sp_load_in,
  input  wire logic [SP_W-1:0]   sp_data_in,
  output logic      [PC_W-1:0]   stack_pointer_out,
  // program counter
  input  wire logic              pc_incr_in,
  input  wire logic              pc_load_in,
  input  wire logic [PC_W-1:0]   pc_data_in,
  output logic      [PC_W-1:0]   program_counter_out,
  output logic      [MAP_BITS-1:0] fetch_addr_out,
  // condition flags
  input  wire logic [3:0]        flags_we_in,
  input  wire logic [3:0]        flags_data_in,
  input  wire logic              flags_byte_load_in,
  input  wire logic [DATA_W-1:0] flags_byte_in,
  input  wire logic              mask_clear_instruction_in,
  input  wire logic              wait_instruction_in,
  input  wire logic              int_stacked_in,
  output logic      [DATA_W-1:0] condition_flags_register_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // data registers carry no reset: device reset must leave them alone,
  // so they sit apart from the reset-affected control state
  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] idx;
    logic              half;
    logic              neg;
    logic              zero;
    logic              carry;
  } cpmr_data_state_type;

  typedef struct packed {
    logic [PC_W-1:0] pc;
    logic            imask;
  } cpmr_ctrl_state_type;

  cpmr_data_state_type data_reg;
  cpmr_data_state_type data_next;
  cpmr_ctrl_state_type ctrl_reg;
  cpmr_ctrl_state_type ctrl_next;

  cpmr_core_if core ();

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  cpmr_stack_ptr u_stack (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .core       (core.stack)
  );

  cpmr_index_addr u_index (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .core       (core.index)
  );

  assign core.sp_push   = sp_push_in;
  assign core.sp_pull   = sp_pull_in;
  assign core.sp_reset  = stack_pointer_reset_instruction_in;
  assign core.sp_load   = sp_load_in;
  assign core.sp_data   = sp_data_in;
  assign core.ix_req    = ix_req_in;
  assign core.ix_mode   = cpmr_ix_mode_type'(ix_mode_in);
  assign core.ix_offset = ix_offset_in;
  // index address always formed from the value already held
  assign core.ix_value  = data_reg.idx;

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  always_comb
  begin
    data_next = data_reg;
    if (acc_load_in)
      data_next.acc = acc_data_in;
    if (idx_load_in)
      data_next.idx = idx_data_in;
    if (flags_byte_load_in)
    begin
      data_next.half  = flags_byte_in[CCR_H];
      data_next.neg   = flags_byte_in[CCR_N];
      data_next.zero  = flags_byte_in[CCR_Z];
      data_next.carry = flags_byte_in[CCR_C];
    end
    else
    begin
      if (flags_we_in[3])
        data_next.half  = flags_data_in[3];
      if (flags_we_in[2])
        data_next.neg   = flags_data_in[2];
      if (flags_we_in[1])
        data_next.zero  = flags_data_in[1];
      if (flags_we_in[0])
        data_next.carry = flags_data_in[0];
    end
    // hold everything while reset is low, whatever the strobes do
    if (!rst_n_in)
      data_next = data_reg;
  end

  always_ff @(posedge clk_sys_in)
  begin
    data_reg <= data_next;
  end

  // ----------------------------------------------------------------
  // program counter and interrupt mask
  // ----------------------------------------------------------------
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (pc_load_in)
      ctrl_next.pc = pc_data_in;
    else if (pc_incr_in)
      ctrl_next.pc = ctrl_reg.pc + 16'h0001;
    // interrupt entry wins over any clear in the same cycle
    if (int_stacked_in)
      ctrl_next.imask = 1'b1;
    else if (flags_byte_load_in)
      ctrl_next.imask = flags_byte_in[CCR_I];
    else if (mask_clear_instruction_in || wait_instruction_in)
      ctrl_next.imask = 1'b0;
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      ctrl_reg <= '{pc: PC_RESET, imask: 1'b1};
    else
      ctrl_reg <= ctrl_next;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign acc_out             = data_reg.acc;
  assign idx_out             = data_reg.idx;
  assign ea_out              = core.ea;
  assign ea_valid_out        = core.ea_valid;
  assign stack_pointer_out   = cpmr_sp_addr(core.sp_val);
  assign program_counter_out = ctrl_reg.pc;
  // upper lines beyond the memory map are simply not brought out
  assign fetch_addr_out      = ctrl_reg.pc[MAP_BITS-1:0];
  assign condition_flags_register_out = {CCR_ONES, data_reg.half, ctrl_reg.imask,
                                         data_reg.neg, data_reg.zero,
                                         data_reg.carry};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  logic sp_step_only;
  assign sp_step_only = !stack_pointer_reset_instruction_in && !sp_load_in;

  property p_sp_wrap;
    core.sp_val == 6'h00 && sp_push_in && !sp_pull_in && sp_step_only
      |=> stack_pointer_out == cpmr_sp_addr(SP_TOP);
  endproperty
  a_sp_wrap: assert property (p_sp_wrap) else $error("push at bottom did not wrap");

  property p_sp_rsp;
    stack_pointer_reset_instruction_in |=> stack_pointer_out == cpmr_sp_addr(SP_TOP);
  endproperty
  a_sp_rsp: assert property (p_sp_rsp) else $error("stack reset not at top");

  property p_sp_push;
    sp_push_in && !sp_pull_in && sp_step_only
      |=> core.sp_val == $past(core.sp_val) - 6'h01;
  endproperty
  a_sp_push: assert property (p_sp_push) else $error("push did not decrement");

  property p_sp_pull;
    sp_pull_in && !sp_push_in && sp_step_only
      |=> core.sp_val == $past(core.sp_val) + 6'h01;
  endproperty
  a_sp_pull: assert property (p_sp_pull) else $error("pull did not increment");

  property p_sp_page;
    stack_pointer_out[15:6] == SP_PAGE;
  endproperty
  a_sp_page: assert property (p_sp_page) else $error("stack page bits wrong");

  property p_sp_interrupt;
    (sp_push_in && !sp_pull_in && sp_step_only) [*5]
      |=> core.sp_val == $past(core.sp_val, 5) - 6'h05;
  endproperty
  a_sp_interrupt: assert property (p_sp_interrupt) else $error("five pushes misplaced");

  property p_acc_load;
    acc_load_in |=> acc_out == $past(acc_data_in);
  endproperty
  a_acc_load: assert property (p_acc_load) else $error("accumulator load lost");

  property p_idx_hold;
    !idx_load_in |=> $stable(idx_out);
  endproperty
  a_idx_hold: assert property (p_idx_hold) else $error("index changed unasked");

  property p_pc_incr;
    pc_incr_in && !pc_load_in |=> program_counter_out == $past(program_counter_out) + 16'h0001;
  endproperty
  a_pc_incr: assert property (p_pc_incr) else $error("program counter did not step");

  property p_pc_load;
    pc_load_in |=> program_counter_out == $past(pc_data_in);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("program counter load lost");

  property p_pc_idle;
    !pc_load_in && !pc_incr_in |=> $stable(program_counter_out);
  endproperty
  a_pc_idle: assert property (p_pc_idle) else $error("program counter drifted");

  property p_ccr_ones;
    condition_flags_register_out[7:5] == CCR_ONES;
  endproperty
  a_ccr_ones: assert property (p_ccr_ones) else $error("upper flag bits not one");

  property p_int_mask;
    int_stacked_in |=> condition_flags_register_out[CCR_I];
  endproperty
  a_int_mask: assert property (p_int_mask) else $error("mask not set on entry");

  property p_mask_clear;
    $fell(condition_flags_register_out[CCR_I])
      |-> $past(mask_clear_instruction_in || wait_instruction_in || flags_byte_load_in);
  endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("mask cleared without cause");

  property p_flag_write;
    flags_we_in[0] && !flags_byte_load_in
      |=> condition_flags_register_out[CCR_C] == $past(flags_data_in[0]);
  endproperty
  a_flag_write: assert property (p_flag_write) else $error("carry flag load lost");

  property p_idx_load;
    idx_load_in |=> idx_out == $past(idx_data_in);
  endproperty
  a_idx_load: assert property (p_idx_load) else $error("index load lost");

  property p_sp_load;
    sp_load_in && !stack_pointer_reset_instruction_in |=> core.sp_val == $past(sp_data_in);
  endproperty
  a_sp_load: assert property (p_sp_load) else $error("pointer load lost");

  property p_sp_both;
    sp_push_in && sp_pull_in && sp_step_only |=> $stable(core.sp_val);
  endproperty
  a_sp_both: assert property (p_sp_both) else $error("push with pull moved pointer");

  property p_ix_page;
    ix_req_in && ix_mode_in == IX_NONE |=> ea_out[15:8] == 8'h00;
  endproperty
  a_ix_page: assert property (p_ix_page) else $error("no-offset high byte not zero");

  property p_ea_valid;
    ix_req_in |=> ea_valid_out;
  endproperty
  a_ea_valid: assert property (p_ea_valid) else $error("address valid missing");

  property p_ea_idle;
    !ix_req_in |=> !ea_valid_out;
  endproperty
  a_ea_idle: assert property (p_ea_idle) else $error("address valid without request");

  property p_fetch_map;
    fetch_addr_out == program_counter_out[MAP_BITS-1:0];
  endproperty
  a_fetch_map: assert property (p_fetch_map) else $error("fetch address off the map");

  property p_cov_wrap;
    core.sp_val == 6'h00 && sp_push_in ##1 core.sp_val == SP_TOP;
  endproperty
  c_cov_wrap: cover property (p_cov_wrap);

  property p_cov_entry;
    sp_push_in [*5] ##1 int_stacked_in ##1 pc_load_in;
  endproperty
  c_cov_entry: cover property (p_cov_entry);

  property p_cov_cli;
    condition_flags_register_out[CCR_I] && mask_clear_instruction_in ##1
      !condition_flags_register_out[CCR_I];
  endproperty
  c_cov_cli: cover property (p_cov_cli);

endmodule // cpmr_regs
`default_nettype wire

// file: dv/cpmr_seq_model.sv
// sequencer model that stacks for calls and interrupt entry, then loads a target
`timescale 1ns/10ps
`default_nettype none
module cpmr_seq_model
  import cpmr_pkg::*;
(
  // clock
  input  wire logic            clk_sys_in,
  // strobes toward the register block
  output logic                 push_out,
  output logic                 stacked_out,
  output logic                 pc_load_out,
  output logic      [PC_W-1:0] pc_data_out
);
  // ----------------------------------------------------------------
  // idle levels
  // ----------------------------------------------------------------
  initial
  begin
    push_out    = 1'b0;
    stacked_out = 1'b0;
    pc_load_out = 1'b0;
    pc_data_out = 16'h0000;
  end

  // ----------------------------------------------------------------
  // one call (two bytes) or one interrupt entry (five bytes)
  // ----------------------------------------------------------------
  task automatic run(input int n, input logic intr, input logic [PC_W-1:0] tgt);
    @(posedge clk_sys_in) push_out <= 1'b1;
    repeat (n) @(posedge clk_sys_in);
    push_out    <= 1'b0;
    stacked_out <= intr;
    if (intr)
      @(posedge clk_sys_in) stacked_out <= 1'b0;
    pc_load_out <= 1'b1;
    pc_data_out <= tgt;
    @(posedge clk_sys_in) pc_load_out <= 1'b0;
    // released data lines must not keep showing the target
    pc_data_out <= ~tgt;
  endtask
endmodule // cpmr_seq_model
`default_nettype wire

// file: dv/cpmr_regs_test.sv
// self-checking bench of the cpu programming model registers
`timescale 1ns/10ps
`default_nettype none
module cpmr_regs_test;
  import cpmr_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0;
  logic acc_ld = 1'b0, idx_ld = 1'b0, ix_req = 1'b0, push = 1'b0, pull = 1'b0;
  logic rsi = 1'b0, sp_ld = 1'b0, pc_inc = 1'b0, pc_ld = 1'b0, fb_ld = 1'b0;
  logic mcl = 1'b0, wai = 1'b0;
  logic [7:0]  acc_d = 8'h00, idx_d = 8'h00, fb = 8'h00;
  logic [2:0]  ix_mode = 3'h1;
  logic [15:0] ix_off = 16'h0000, pc_d = 16'h0000;
  logic [5:0]  sp_d = 6'h00;
  logic [3:0]  f_we = 4'h0, f_d = 4'h0;
  logic        m_push, m_stk, m_pcl, all_push, all_pcl;
  logic [15:0] m_pcd, all_pcd, ea, sp, pc;
  logic [7:0]  acc, idx, condition_flags_register;
  logic [12:0] fa;
  logic        eav;
  int          bad_count = 0, n_compared = 0;

  assign all_push = push | m_push;
  assign all_pcl  = pc_ld | m_pcl;
  assign all_pcd  = m_pcl ? m_pcd : pc_d;

  always #5 clk_sys_in = ~clk_sys_in;

  cpmr_regs cpmr_regs_i (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .acc_load_in(acc_ld), .acc_data_in(acc_d), .acc_out(acc),
    .idx_load_in(idx_ld), .idx_data_in(idx_d), .idx_out(idx),
    .ix_req_in(ix_req), .ix_mode_in(ix_mode), .ix_offset_in(ix_off),
    .ea_out(ea), .ea_valid_out(eav),
    .sp_push_in(all_push), .sp_pull_in(pull),
    .stack_pointer_reset_instruction_in(rsi), .sp_load_in(sp_ld),
    .sp_data_in(sp_d), .stack_pointer_out(sp),
    .pc_incr_in(pc_inc), .pc_load_in(all_pcl), .pc_data_in(all_pcd),
    .program_counter_out(pc), .fetch_addr_out(fa),
    .flags_we_in(f_we), .flags_data_in(f_d), .flags_byte_load_in(fb_ld),
    .flags_byte_in(fb), .mask_clear_instruction_in(mcl),
    .wait_instruction_in(wai), .int_stacked_in(m_stk),
    .condition_flags_register_out(condition_flags_register));

  cpmr_seq_model cpmr_seq_model_i (
    .clk_sys_in(clk_sys_in), .push_out(m_push), .stacked_out(m_stk),
    .pc_load_out(m_pcl), .pc_data_out(m_pcd));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // n edges of a strobe already raised, then drop it and let outputs settle
  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys_in);
    {acc_ld, idx_ld, ix_req, push, pull, rsi, sp_ld} <= 7'h00;
    {pc_inc, pc_ld, fb_ld, mcl, wai} <= 5'h00;
    f_we <= 4'h0;
    #1;
  endtask

  function automatic logic [15:0] spa(input logic [5:0] s);
    spa = {SP_PAGE, s};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(sp, spa(SP_TOP));
    chk(condition_flags_register[7:5], CCR_ONES);
    chk(condition_flags_register[CCR_I], 1'b1);
    chk(pc, PC_RESET);
    chk(eav, 1'b0);
  endtask

  task automatic t_keep;
    @(posedge clk_sys_in) {acc_ld, idx_ld, mcl} <= 3'h7;
    acc_d <= 8'hA5; idx_d <= 8'h3C; f_we <= 4'hF; f_d <= 4'hA;
    hold(1);
    chk(acc, 8'hA5);
    chk(condition_flags_register, 8'hF2);
    // strobes held across the reset must be ignored
    @(posedge clk_sys_in) rst_n_in <= 1'b0;
    {acc_ld, idx_ld} <= 2'h3; acc_d <= 8'h00; idx_d <= 8'h00; f_we <= 4'hF;
    f_d <= 4'h5;
    hold(2);
    chk(acc, 8'hA5);
    chk(idx, 8'h3C);
    chk(condition_flags_register, 8'hFA);
    @(posedge clk_sys_in) rst_n_in <= 1'b1;
  endtask

  task automatic ix_case(input logic [7:0] x, input logic [2:0] m,
                         input logic [15:0] off, input logic [15:0] exp);
    @(posedge clk_sys_in) idx_ld <= 1'b1; idx_d <= x;
    @(posedge clk_sys_in) idx_ld <= 1'b0; ix_req <= 1'b1; ix_mode <= m; ix_off <= off;
    hold(1);
    chk(eav, 1'b1);
    chk(ea, exp);
    @(posedge clk_sys_in) #1;
    chk(eav, 1'b0);
  endtask

  task automatic t_index;
    ix_case(8'h20, 3'h1, 16'hFF77, 16'h0020);
    ix_case(8'hFF, 3'h2, 16'hAAFF, 16'h01FE);
    ix_case(8'h20, 3'h4, 16'hFFF0, 16'h0010);
    ix_case(8'h55, 3'h3, 16'h1234, 16'h0010);
  endtask

  task automatic t_stack;
    @(posedge clk_sys_in) push <= 1'b1;
    hold(1);
    chk(sp, spa(6'h3E));
    @(posedge clk_sys_in) push <= 1'b1;
    hold(62);
    chk(sp, 16'h00C0);
    @(posedge clk_sys_in) push <= 1'b1;
    hold(1);
    chk(sp, 16'h00FF);
    @(posedge clk_sys_in) pull <= 1'b1;
    hold(1);
    chk(sp, 16'h00C0);
    @(posedge clk_sys_in) {push, pull} <= 2'h3;
    hold(1);
    chk(sp, 16'h00C0);
    @(posedge clk_sys_in) sp_ld <= 1'b1; sp_d <= 6'h15; push <= 1'b1;
    hold(1);
    chk(sp, 16'h00D5);
    @(posedge clk_sys_in) rsi <= 1'b1; push <= 1'b1;
    hold(1);
    chk(sp, 16'h00FF);
  endtask

  task automatic t_pc;
    @(posedge clk_sys_in) pc_ld <= 1'b1; pc_d <= 16'h1FFF;
    hold(1);
    @(posedge clk_sys_in) pc_inc <= 1'b1;
    hold(1);
    chk(pc, 16'h2000);
    chk(fa, 13'h0000);
    @(posedge clk_sys_in) {pc_inc, pc_ld} <= 2'h3; pc_d <= 16'h0ABC;
    hold(1);
    chk(pc, 16'h0ABC);
  endtask

  task automatic t_flags;
    @(posedge clk_sys_in) fb_ld <= 1'b1; fb <= 8'h1F; f_we <= 4'hF; f_d <= 4'h0;
    hold(1);
    chk(condition_flags_register, 8'hFF);
    @(posedge clk_sys_in) f_we <= 4'h4; f_d <= 4'hB;
    hold(1);
    chk(condition_flags_register, 8'hFB);
    @(posedge clk_sys_in) wai <= 1'b1;
    hold(1);
    chk(condition_flags_register, 8'hF3);
  endtask

  task automatic t_entry;
    int i;
    cpmr_seq_model_i.run(2, 1'b0, 16'h0345);
    #1;
    chk(sp, 16'h00FD);
    chk(pc, 16'h0345);
    fork
      cpmr_seq_model_i.run(5, 1'b1, 16'h1FFA);
      begin
        for (i = 0; i < 20 && m_stk !== 1'b1; i++)
          @(posedge clk_sys_in) #1;
        chk(sp, 16'h00F8);
        chk(condition_flags_register[CCR_I], 1'b0);
        @(posedge clk_sys_in) #1;
        chk(condition_flags_register[CCR_I], 1'b1);
      end
    join
    #1;
    chk(pc, 16'h1FFA);
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    #1;
    t_reset();
    t_keep();
    t_index();
    t_stack();
    t_pc();
    t_flags();
    t_entry();
    close_out();
  end

  initial
  begin
    repeat (2000) @(posedge clk_sys_in);
    bad_count++;
    close_out();
  end
endmodule // cpmr_regs_test
`default_nettype wire
